// file: testbench.sv
/* self-checking bench of uefc_ctrl; the bench stands in for the core. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    uefc_pkg::uefc_reg_req_t reg_req = '0;
    uefc_pkg::uefc_rx_char_t rx_char = '0;
    logic tx_push = 1'b0, tsr_empty = 1'b1, rx_busy = 1'b0, modem_sel = 1'b0;
    logic modem_rts = 1'b0, modem_dtr = 1'b0;
    logic [1:0] pause = 2'b00;
    logic [7:0] lvl_in = 8'h00, reg_rdata, tx_fifo_level, rx_store_data;
    logic tx_load, tx_empty_irq, tx_trig_irq, rx_enable, ir_rx, rx_store;
    logic special_irq, xoff_irq, rx_trig_irq, rts_n, dtr_n, enh_write_en, rx_pin, cts_n, dsr_n;
    logic [3:0] sw_flow_sel;
    int bad_count = 0, n_compared = 0, n_empty = 0, n_trig = 0;
    always #2 core_clk = ~core_clk;
    uefc_ctrl i_uefc_ctrl (.core_clk, .nrst, .reg_req, .reg_rdata, .tx_push, .tsr_empty,
        .tx_load, .tx_fifo_level, .tx_empty_irq, .tx_trig_irq, .rx_pin, .rx_busy, .rx_enable,
        .ir_rx, .rx_char, .second_pause_char(8'hA5), .rx_store, .rx_store_data, .special_irq,
        .xoff_irq, .rx_fifo_level(lvl_in), .rx_trigger(8'h08), .rx_next_upper(8'h0C),
        .rx_next_lower(8'h04), .rx_trig_irq, .modem_sel, .modem_rts, .modem_dtr, .cts_n,
        .dsr_n, .rts_n, .dtr_n, .sw_flow_sel, .enh_write_en);
    uefc_far_end i_uefc_far_end (.core_clk, .pause, .rx_pin, .cts_n, .dsr_n);
    // core stand-in: shifter busy one cycle per load; event counters
    always @(posedge core_clk) begin
        tsr_empty <= !tx_load;
        // count only once the design has left reset, so no unknown creeps in
        if (nrst) begin
            n_empty <= n_empty + int'(tx_empty_irq);
            n_trig <= n_trig + int'(rx_trig_irq);
        end
    end
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    // one register access, then one idle cycle
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        tick(1);
        reg_req <= '0;
        tick(1);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(reg_rdata, exp);
    endtask : rd
    task automatic push(input int n);
        tx_push <= 1'b1;
        tick(n);
        tx_push <= 1'b0;
        tick(1);
    endtask : push
    // bounded wait for a tx level
    task automatic until_lvl(input logic [7:0] v);
        for (int i = 0; i < 400; i++) begin
            if (tx_fifo_level === v) return;
            tick(1);
        end
        bad_count++;
        report_and_stop();
    endtask : until_lvl
    task automatic rx(input logic [7:0] d, input logic [2:0] exp);
        rx_char <= '{valid: 1'b1, data: d};
        tick(1);
        rx_char <= '0;
        #1;
        chk({5'h00, rx_store, special_irq, xoff_irq}, {5'h00, exp});
        if (rx_store === 1'b1) chk(rx_store_data, d);
        tick(1);
    endtask : rx
    task automatic t_regs;
        chk({6'h00, rts_n, dtr_n}, 8'h03);
        rd(4'h7, 8'hFF);
        rd(4'h9, 8'h00);
        rd(4'h8, 8'h00);
        bus(1'b1, 4'h8, 8'hC5);
        rd(4'h8, 8'hC5);
        bus(1'b1, 4'h7, 8'h5A);
        rd(4'h7, 8'h5A);
        rd(4'h3, 8'h00);
        bus(1'b1, 4'h8, 8'h00);
    endtask : t_regs
    task automatic t_halt;
        int e0;
        bus(1'b1, 4'h6, 8'h08);
        push(1);
        until_lvl(8'h00);
        bus(1'b1, 4'h9, 8'h10);
        bus(1'b1, 4'h6, 8'h08);
        bus(1'b1, 4'h9, 8'h00);
        bus(1'b1, 4'h6, 8'h00);
        e0 = n_empty;
        push(66);
        tick(6);
        chk(tx_fifo_level, 8'h40);
        chk(8'(n_empty - e0), 8'h00);
        bus(1'b1, 4'hA, 8'h40);
        chk({7'h00, tx_trig_irq}, 8'h00);
        bus(1'b1, 4'h9, 8'h10);
        bus(1'b1, 4'h6, 8'h00);
        until_lvl(8'h3F);
        tick(1);
        chk({7'h00, tx_trig_irq}, 8'h01);
        until_lvl(8'h00);
        tick(1);
        chk({7'h00, n_empty > e0}, 8'h01);
        bus(1'b1, 4'hA, 8'h00);
        tick(1);
        chk({7'h00, tx_trig_irq}, 8'h00);
    endtask : t_halt
    task automatic t_cts;
        bus(1'b1, 4'h9, 8'h90);
        for (int s = 0; s < 2; s++) begin
            modem_sel <= 1'(s);
            pause <= (s == 1) ? 2'b01 : 2'b10;
            push(1);
            until_lvl(8'h00);
            pause <= (s == 1) ? 2'b10 : 2'b01;
            tick(4);
            push(1);
            tick(8);
            chk(tx_fifo_level, 8'h01);
            pause <= 2'b00;
            until_lvl(8'h00);
        end
        modem_sel <= 1'b0;
    endtask : t_cts
    task automatic t_rts;
        modem_rts <= 1'b1;
        modem_dtr <= 1'b1;
        tick(3);
        chk({6'h00, rts_n, dtr_n}, 8'h00);
        bus(1'b1, 4'h9, 8'h50);
        lvl_in <= 8'h08;
        tick(3);
        chk({7'h00, rts_n}, 8'h00);
        chk(8'(n_trig), 8'h01);
        lvl_in <= 8'h0C;
        tick(3);
        chk({7'h00, rts_n}, 8'h01);
        lvl_in <= 8'h04;
        tick(3);
        chk({7'h00, rts_n}, 8'h01);
        lvl_in <= 8'h03;
        tick(3);
        chk({7'h00, rts_n}, 8'h00);
        bus(1'b1, 4'h8, 8'h82);
        lvl_chk(8'h0C, 1'b1);
        lvl_chk(8'h03, 1'b0);
        bus(1'b1, 4'h8, 8'hC2);
        lvl_chk(8'h0D, 1'b0);
        lvl_chk(8'h0E, 1'b1);
        lvl_chk(8'h03, 1'b1);
        lvl_chk(8'h01, 1'b0);
        bus(1'b1, 4'h8, 8'h00);
        lvl_in <= 8'h00;
    endtask : t_rts
    // set the rx level, let the pin settle, then judge rts_n
    task automatic lvl_chk(input logic [7:0] l, input logic e);
        lvl_in <= l;
        tick(3);
        chk({7'h00, rts_n}, {7'h00, e});
    endtask : lvl_chk
    // auto direction: rts_n high from push until the shifter drains
    task automatic t_dir;
        int e0;
        bus(1'b1, 4'h8, 8'h20);
        chk({7'h00, rts_n}, 8'h00);
        push(1);
        e0 = n_empty;
        chk({7'h00, rts_n}, 8'h01);
        tick(2);
        chk(8'(n_empty - e0), 8'h00);
        chk({7'h00, rts_n}, 8'h01);
        tick(4);
        chk(8'(n_empty - e0), 8'h01);
        chk({7'h00, rts_n}, 8'h00);
        bus(1'b1, 4'h8, 8'h00);
    endtask : t_dir
    task automatic t_rx;
        bus(1'b1, 4'h9, 8'h30);
        rx(8'hA5, 3'b110);
        rx(8'h5A, 3'b100);
        bus(1'b1, 4'h9, 8'h10);
        bus(1'b1, 4'h9, 8'h31);
        rx(8'hA5, 3'b011);
        bus(1'b1, 4'h9, 8'h10);
        rx_busy <= 1'b1;
        bus(1'b1, 4'h6, 8'h04);
        tick(2);
        chk({7'h00, rx_enable}, 8'h01);
        rx_busy <= 1'b0;
        tick(2);
        chk({7'h00, rx_enable}, 8'h00);
        bus(1'b1, 4'h6, 8'h00);
        tick(1);
        chk({7'h00, rx_enable}, 8'h01);
        bus(1'b1, 4'h8, 8'h10);
        fork
            i_uefc_far_end.frame(8'h00);
            begin
                tick(6);
                chk({7'h00, ir_rx}, 8'h01);
            end
        join
        tick(3);
        chk({7'h00, ir_rx}, 8'h00);
        bus(1'b1, 4'h8, 8'h00);
        tick(1);
        chk({7'h00, ir_rx}, 8'h01);
    endtask : t_rx
    initial begin
        tick(20);
        nrst <= 1'b1;
        tick(1);
        t_regs();
        t_halt();
        t_cts();
        t_rts();
        t_dir();
        t_rx();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire

// file: uefc_ctrl.sv
/*
 * enhanced control of one uart channel: tx/rx halt, scratch byte,
 * feature and enhanced feature registers, tx level counter, trigger,
 * auto rs-485 and hardware flow control, special character detect.
 * assumes the surrounding channel supplies the shift register status,
 * rx fifo level, trigger levels and the second pause character on
 * core_clk; modem pins are asynchronous.
 */
`include "uefc_map.svh"
`timescale 1ns/1ps
`default_nettype none
// How it works
// - transmitter disable bit halts shift loading
// - clearing disable resumes; resets to enabled
// - rx disable finishes current char, then stops
// - rx re-enables only on idle high line
// - scratch byte read/write, resets to FF
// - tables A-C use next trigger thresholds
// - rs-485 direction high on rts while transmitting, cts/rts selected
// - rs-485 moves tx interrupt to shifter empty
// - infrared rx polarity select, default normal
// - hysteresis applies only with table D
// - hysteresis code to character count map
// - auto cts/dsr halts tx while input high
// - auto rts/dtr interrupt and threshold drive
// - manual pin state enables auto, else GPIO
// - special char match stored, flagged
// - second pair match skips fifo, two interrupts
// - enhanced enable gates enhanced bit writes
// - software flow control select decoding
// - tx fifo level reports 0 to 64
// - tx trigger interrupt when level below value
// - selector picks cts/rts or dsr/dtr
module uefc_ctrl #(
    parameter int LVL_W = 8
) (
    // clock and synchronous active-low reset
    input wire logic core_clk,
    input wire logic nrst,
    // host register port, one access per cycle
    input wire uefc_pkg::uefc_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // transmit fifo bookkeeping against the core shifter
    input wire logic tx_push,
    input wire logic tsr_empty,
    output logic tx_load,
    output logic [LVL_W-1:0] tx_fifo_level,
    output logic tx_empty_irq,
    output logic tx_trig_irq,
    // receive line, synchronised here, and core receiver state
    input wire logic rx_pin,
    input wire logic rx_busy,
    output logic rx_enable,
    output logic ir_rx,
    // finished characters screened for the special pause char
    input wire uefc_pkg::uefc_rx_char_t rx_char,
    input wire logic [7:0] second_pause_char,
    output logic rx_store,
    output logic [7:0] rx_store_data,
    output logic special_irq,
    output logic xoff_irq,
    // receive fifo level and thresholds from the core
    input wire logic [LVL_W-1:0] rx_fifo_level,
    input wire logic [LVL_W-1:0] rx_trigger,
    input wire logic [LVL_W-1:0] rx_next_upper,
    input wire logic [LVL_W-1:0] rx_next_lower,
    output logic rx_trig_irq,
    // host pin bits and the modem handshake pins
    input wire logic modem_sel,
    input wire logic modem_rts,
    input wire logic modem_dtr,
    input wire logic cts_n,
    input wire logic dsr_n,
    output logic rts_n,
    output logic dtr_n,
    // enhanced fields handed on to the rest of the channel
    output logic [3:0] sw_flow_sel,
    output logic enh_write_en
);
    // registers
    logic [7:0] aux_q;          // aux_line_control
    logic [7:0] scratch_q;      // scratch_byte
    logic [7:0] feature_q;      // feature_control
    logic [7:0] enhanced_q;     // enhanced_feature
    logic [7:0] tx_fifo_trigger_q;        // tx_fifo_trigger
    logic [LVL_W-1:0] tx_fifo_level_q;  // tx_fifo_level
    logic [7:0] rdata_q;
    // pin synchronisers
    logic rx_s1_q, rx_s2_q, cts_s1_q, cts_s2_q, dsr_s1_q, dsr_s2_q;
    // transmit side: load strobe, interrupt flags, shifter state last cycle
    logic tx_load_q, tx_empty_irq_q, tx_trig_irq_q, tsr_empty_q;
    // receive side: enable, ir level, store strobe and screening flags
    logic rx_en_q, ir_rx_q, rx_store_q, special_q, xoff_q, rx_trig_q;
    logic [7:0] rx_data_q; // byte handed to the rx fifo
    // flow control: hold request and the two pin levels
    logic flow_hold_q, rts_n_q, dtr_n_q;
    logic [LVL_W-1:0] rxlvl_q; // rx level one cycle ago

    // register decode
    wire wr_aux = reg_req.wr && reg_req.addr == `UEFC_OFF_AUX;
    wire wr_scr = reg_req.wr && reg_req.addr == `UEFC_OFF_SCRATCH;
    wire wr_fc = reg_req.wr && reg_req.addr == `UEFC_OFF_FEATURE;
    wire wr_ef = reg_req.wr && reg_req.addr == `UEFC_OFF_ENHANCED;
    wire wr_trg = reg_req.wr && reg_req.addr == `UEFC_OFF_TXLVL;
    wire enh_en = enhanced_q[`UEFC_EF_ENH];
    // gated bits only change while enhanced writes are open
    wire [7:0] gate_mask = enh_en ? `UEFC_AUX_GATED : `UEFC_RST_ZERO;
    wire [7:0] aux_d = (aux_q & ~gate_mask) | (reg_req.wdata & gate_mask);
    // read mux; write-only and unmapped offsets read zero
    wire [7:0] rd_mux =
        reg_req.addr == `UEFC_OFF_SCRATCH ? scratch_q :
        reg_req.addr == `UEFC_OFF_FEATURE ? feature_q :
        reg_req.addr == `UEFC_OFF_ENHANCED ? enhanced_q :
        reg_req.addr == `UEFC_OFF_TXLVL ? 8'(tx_fifo_level_q) : `UEFC_RST_ZERO;

    // transmit side
    wire tx_dis = aux_q[`UEFC_AUX_TXDIS];
    wire flow_in = modem_sel ? dsr_s2_q : cts_s2_q;
    wire cts_halt = enhanced_q[`UEFC_EF_AUTOCTS] && flow_in;
    // one load per idle shifter; tx_load_q keeps loads a cycle apart
    wire tx_go = tx_fifo_level_q != '0 && tsr_empty && !tx_load_q && !tx_dis && !cts_halt;
    // a push into a full fifo is dropped; the level stops at the depth
    wire push_ok = tx_push && tx_fifo_level_q != LVL_W'(`UEFC_FIFO_DEPTH);
    wire [LVL_W-1:0] tx_fifo_level_d = tx_fifo_level_q + LVL_W'(push_ok) - LVL_W'(tx_go);
    wire rs485 = feature_q[`UEFC_FC_RS485];
    // holding side empties when the last byte moves to the shifter
    wire hold_empty_ev = tx_go && tx_fifo_level_q == LVL_W'(1);
    wire tsr_empty_ev = tsr_empty && !tsr_empty_q && tx_fifo_level_q == '0;
    wire tx_irq_d = rs485 ? tsr_empty_ev : hold_empty_ev;
    // a level, not a pulse: rewriting the trigger takes effect at once
    wire tx_trig_d = tx_fifo_level_d < LVL_W'(tx_fifo_trigger_q);
    // direction high from the moment a byte is queued until line done
    wire dir_busy = push_ok || tx_fifo_level_q != '0 || !tsr_empty || tx_load_q;

    // receive side
    wire rx_dis = aux_q[`UEFC_AUX_RXDIS];
    // finish a running char when disabled, restart only on idle line
    wire rx_en_d = rx_dis ? (rx_en_q && rx_busy) : (rx_en_q || rx_s2_q);
    wire ir_d = rx_s2_q ^ feature_q[`UEFC_FC_IRPOL];
    wire spec_en = enhanced_q[`UEFC_EF_SPECIAL];
    // receive comparison restricted to the second pair
    wire pair2 = enhanced_q[1:0] == 2'b01;
    wire match = rx_char.valid && rx_char.data == second_pause_char;
    wire sp_hit = spec_en && match;
    wire store_d = rx_char.valid && !(sp_hit && pair2);

    // hardware flow thresholds
    wire table_d = feature_q[`UEFC_FC_TABLE_HI] && feature_q[`UEFC_FC_TABLE_LO];
    wire [5:0] hyst = hyst_chars(feature_q[`UEFC_FC_HYST_HI:0]);
    // hysteresis code 0 keeps the neighbouring trigger levels
    wire use_hyst = table_d && hyst != 6'h00;
    wire [LVL_W:0] up_h = {1'b0, rx_trigger} + (LVL_W+1)'(hyst);
    wire [LVL_W:0] lo_h = {1'b0, rx_trigger} - (LVL_W+1)'(hyst);
    // the lower threshold cannot go under an empty fifo
    wire [LVL_W-1:0] lo_sat = lo_h[LVL_W] ? '0 : lo_h[LVL_W-1:0];
    wire [LVL_W:0] upper = use_hyst ? up_h : {1'b0, rx_next_upper};
    wire [LVL_W-1:0] lower = use_hyst ? lo_sat : rx_next_lower;
    wire auto_rts = enhanced_q[`UEFC_EF_AUTORTS];
    // pin held off between the upper and lower crossings
    wire hold_d = !auto_rts ? 1'b0 :
        ({1'b0, rx_fifo_level} >= upper) ? 1'b1 :
        (rx_fifo_level < lower) ? 1'b0 : flow_hold_q;
    // one pulse as the level climbs onto the trigger
    wire trig_ev = auto_rts && rx_fifo_level >= rx_trigger && rxlvl_q < rx_trigger;
    // pin drive: rs-485 owns rts while cts/rts selected, auto only if host asserted the pin
    wire rts_pin_d = (rs485 && !modem_sel) ? dir_busy :
        (auto_rts && !modem_sel && modem_rts) ? flow_hold_q : !modem_rts;
    wire dtr_pin_d = (auto_rts && modem_sel && modem_dtr) ? flow_hold_q : !modem_dtr;

    // hysteresis code to characters
    function automatic logic [5:0] hyst_chars(input logic [3:0] code);
        logic [5:0] v;
        v = 6'h00;
        unique case (code)
            4'h0: v = 6'h00;
            4'h1: v = 6'h04;
            4'h2: v = 6'h06;
            4'h3: v = 6'h08;
            4'h4: v = 6'h08;
            4'h5: v = 6'h10;
            4'h6: v = 6'h18;
            4'h7: v = 6'h20;
            4'h8: v = 6'h28;
            4'h9: v = 6'h2C;
            4'hA: v = 6'h30;
            4'hB: v = 6'h34;
            4'hC: v = 6'h0C;
            4'hD: v = 6'h14;
            4'hE: v = 6'h1C;
            4'hF: v = 6'h24;
        endcase
        return v;
    endfunction : hyst_chars

    // two-flop synchronisers for the line and modem inputs
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            // idle line and released pins read high
            {rx_s1_q, rx_s2_q} <= 2'h3;
            {cts_s1_q, cts_s2_q} <= 2'h3;
            {dsr_s1_q, dsr_s2_q} <= 2'h3;
        end else begin
            {rx_s1_q, rx_s2_q} <= {rx_pin, rx_s1_q};
            {cts_s1_q, cts_s2_q} <= {cts_n, cts_s1_q};
            {dsr_s1_q, dsr_s2_q} <= {dsr_n, dsr_s1_q};
        end
    end

    // software-visible registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            aux_q <= `UEFC_RST_ZERO;
            scratch_q <= `UEFC_RST_SCRATCH;
            feature_q <= `UEFC_RST_ZERO;
            enhanced_q <= `UEFC_RST_ZERO;
            tx_fifo_trigger_q <= `UEFC_RST_ZERO;
            rdata_q <= `UEFC_RST_ZERO;
        end else begin
            if (wr_aux) aux_q <= aux_d;
            if (wr_scr) scratch_q <= reg_req.wdata;
            if (wr_fc) feature_q <= reg_req.wdata;
            if (wr_ef) enhanced_q <= reg_req.wdata;
            if (wr_trg) tx_fifo_trigger_q <= reg_req.wdata;
            // read data holds until the next read
            if (reg_req.rd) rdata_q <= rd_mux;
        end
    end

    // transmit control and level counter
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            tx_fifo_level_q <= '0;
            tx_load_q <= 1'b0;
            tx_empty_irq_q <= 1'b0;
            tx_trig_irq_q <= 1'b0;
            tsr_empty_q <= 1'b1;
        end else begin
            tx_fifo_level_q <= tx_fifo_level_d;
            tx_load_q <= tx_go;
            tx_empty_irq_q <= tx_irq_d;
            tx_trig_irq_q <= tx_trig_d;
            // previous shifter state finds its rising edge
            tsr_empty_q <= tsr_empty;
        end
    end

    // receive control and character screening
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rx_en_q <= 1'b1;
            ir_rx_q <= 1'b0;
            rx_store_q <= 1'b0;
            rx_data_q <= `UEFC_RST_ZERO;
            special_q <= 1'b0;
            xoff_q <= 1'b0;
        end else begin
            rx_en_q <= rx_en_d;
            ir_rx_q <= ir_d;
            rx_store_q <= store_d;
            rx_data_q <= rx_char.data;
            special_q <= sp_hit;
            xoff_q <= sp_hit && pair2;
        end
    end

    // flow control and modem pins
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            flow_hold_q <= 1'b0;
            rxlvl_q <= '0;
            rx_trig_q <= 1'b0;
            rts_n_q <= 1'b1;
            dtr_n_q <= 1'b1;
        end else begin
            flow_hold_q <= hold_d;
            rxlvl_q <= rx_fifo_level;
            rx_trig_q <= trig_ev;
            rts_n_q <= rts_pin_d;
            dtr_n_q <= dtr_pin_d;
        end
    end

    // outputs, all from flops
    assign reg_rdata = rdata_q;
    assign tx_load = tx_load_q;
    assign tx_fifo_level = tx_fifo_level_q;
    assign tx_empty_irq = tx_empty_irq_q;
    assign tx_trig_irq = tx_trig_irq_q;
    assign rx_enable = rx_en_q;
    assign ir_rx = ir_rx_q;
    assign rx_store = rx_store_q;
    assign rx_store_data = rx_data_q;
    assign special_irq = special_q;
    assign xoff_irq = xoff_q;
    assign rx_trig_irq = rx_trig_q;
    assign rts_n = rts_n_q;
    assign dtr_n = dtr_n_q;
    assign sw_flow_sel = enhanced_q[3:0];
    assign enh_write_en = enhanced_q[`UEFC_EF_ENH];
endmodule : uefc_ctrl
`default_nettype wire

// file: uefc_ctrl_asserts.sv
/* checker: port-level assertions on uefc_ctrl.
   assumes aux at offset 6 and enhanced at offset 9. */
`timescale 1ns/1ps
`default_nettype none
module uefc_ctrl_asserts #(
    parameter int LVL_W = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire uefc_pkg::uefc_reg_req_t reg_req,
    input wire logic tx_push,
    input wire logic tx_load,
    input wire logic [LVL_W-1:0] tx_fifo_level,
    input wire uefc_pkg::uefc_rx_char_t rx_char,
    input wire logic [7:0] second_pause_char,
    input wire logic rx_store,
    input wire logic [7:0] rx_store_data,
    input wire logic special_irq,
    input wire logic xoff_irq,
    input wire logic [3:0] sw_flow_sel,
    input wire logic enh_write_en
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic txdis_q; // shadow of the halt bit
    logic spec_q; // shadow of special detect
    wire logic aux_wr = reg_req.wr && reg_req.addr == 4'h6 && enh_write_en;
    wire logic ef_wr = reg_req.wr && reg_req.addr == 4'h9;
    wire logic hit = rx_char.valid && rx_char.data == second_pause_char;
    // follow host writes of the halt bit and the special detect enable
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            txdis_q <= 1'b0;
            spec_q <= 1'b0;
        end else begin
            if (aux_wr) txdis_q <= reg_req.wdata[3];
            if (ef_wr) spec_q <= reg_req.wdata[5];
        end
    end
    property p_halt;
        txdis_q |=> !tx_load;
    endproperty
    a_halt: assert property (p_halt) else $error("load while halted");
    property p_dec;
        tx_load && !$past(tx_push) |-> $past(tx_fifo_level) - tx_fifo_level == LVL_W'(1);
    endproperty
    a_dec: assert property (p_dec) else $error("level not decremented");
    property p_push;
        tx_push && tx_fifo_level < LVL_W'(64) |=>
            int'(tx_fifo_level) + int'(tx_load) == int'($past(tx_fifo_level)) + 1;
    endproperty
    a_push: assert property (p_push) else $error("level not incremented");
    property p_store;
        rx_store |-> $past(rx_char.valid) && rx_store_data == $past(rx_char.data);
    endproperty
    a_store: assert property (p_store) else $error("stored wrong byte");
    property p_quiet;
        !hit |=> !special_irq && !xoff_irq;
    endproperty
    a_quiet: assert property (p_quiet) else $error("irq without match");
    property p_spec;
        spec_q && hit |=> special_irq;
    endproperty
    a_spec: assert property (p_spec) else $error("special match missed");
    property p_second_pause_char;
        spec_q && sw_flow_sel[1:0] == 2'b01 && hit |=> xoff_irq && !rx_store;
    endproperty
    a_second_pause_char: assert property (p_second_pause_char) else $error("pause char mishandled");
    property p_efr;
        ef_wr |=> sw_flow_sel == $past(reg_req.wdata[3:0])
            && enh_write_en == $past(reg_req.wdata[4]);
    endproperty
    a_efr: assert property (p_efr) else $error("enhanced write lost");
endmodule : uefc_ctrl_asserts
bind uefc_ctrl uefc_ctrl_asserts #(.LVL_W(LVL_W)) i_uefc_ctrl_asserts (
    .core_clk, .nrst, .reg_req, .tx_push, .tx_load, .tx_fifo_level, .rx_char,
    .second_pause_char, .rx_store, .rx_store_data, .special_irq, .xoff_irq,
    .sw_flow_sel, .enh_write_en
);
`default_nettype wire

// file: uefc_far_end.sv
/* remote serial equipment: line and modem pins.
   assumes the bench drives pause at clock edges. */
`timescale 1ns/1ps
`default_nettype none
module uefc_far_end (
    input wire logic core_clk,
    input wire logic [1:0] pause,
    output var logic rx_pin,
    output var logic cts_n,
    output var logic dsr_n
);
    initial begin
        rx_pin = 1'b1; // idle line marks high
        cts_n = 1'b0;
        dsr_n = 1'b0;
    end
    // pause requests reach the pins one cycle later
    always @(posedge core_clk) begin
        cts_n <= pause[0];
        dsr_n <= pause[1];
    end
    // one frame, four clocks a bit, lsb first
    task automatic frame(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_pin <= f[i];
            repeat (4) @(posedge core_clk);
        end
    endtask : frame
endmodule : uefc_far_end
`default_nettype wire

// file: uefc_map.svh
/*
 * register offsets, field positions and reset values of the enhanced
 * feature control block. assumes an 8-bit register port with a 4-bit
 * offset.
 */
`ifndef UEFC_MAP_SVH
`define UEFC_MAP_SVH
// register offsets
`define UEFC_OFF_AUX 4'h6
`define UEFC_OFF_SCRATCH 4'h7
`define UEFC_OFF_FEATURE 4'h8
`define UEFC_OFF_ENHANCED 4'h9
`define UEFC_OFF_TXLVL 4'hA
// reset values
`define UEFC_RST_SCRATCH 8'hFF
`define UEFC_RST_ZERO 8'h00
// aux_line_control fields
`define UEFC_AUX_TXDIS 3
`define UEFC_AUX_RXDIS 2
`define UEFC_AUX_GATED 8'hFC
// feature_control fields
`define UEFC_FC_TABLE_HI 7
`define UEFC_FC_TABLE_LO 6
`define UEFC_FC_RS485 5
`define UEFC_FC_IRPOL 4
`define UEFC_FC_HYST_HI 3
// enhanced_feature fields
`define UEFC_EF_AUTOCTS 7
`define UEFC_EF_AUTORTS 6
`define UEFC_EF_SPECIAL 5
`define UEFC_EF_ENH 4
// fifo depth
`define UEFC_FIFO_DEPTH 8'h40
`endif

// file: uefc_pkg.sv
/*
 * types shared by the enhanced feature control block.
 * hard-codes the 4-bit offset and 8-bit data that the map header assumes.
 */
package uefc_pkg;
    // one register access from the host side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } uefc_reg_req_t;
    // one character completed by the receiver
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } uefc_rx_char_t;
endpackage : uefc_pkg
